// File: bgr_amp_model.sv
/*
 * Far-side model: three free-running carrier oscillators and eight
 * amplifiers whose hydrophones report a burst back to the monitor lines.
 * Assumes drive pulses and enables come from the burst gate block.
 */
`timescale 1ns/1ns
`default_nettype none

module bgr_amp_model #(
	parameter int HALF_LOW_NS  = 4240,
	parameter int HALF_MID_NS  = 4040,
	parameter int HALF_HIGH_NS = 3800
) (
	input  wire logic [7:0] drive_pos_i,
	input  wire logic [7:0] drive_neg_i,
	input  wire logic [7:0] amp_enable_i,
	input  wire logic [7:0] fault_i,
	output logic      [2:0] carrier_o,
	output logic      [7:0] monitor_o
);
	// -----------------------------------------------------------------
	// Oscillators, offset so that no edge meets a clock edge.
	// -----------------------------------------------------------------
	initial begin
		carrier_o = 3'b000;
		#7;
		fork
			forever #(HALF_LOW_NS) carrier_o[0] = ~carrier_o[0];
			forever #(HALF_MID_NS) carrier_o[1] = ~carrier_o[1];
			forever #(HALF_HIGH_NS) carrier_o[2] = ~carrier_o[2];
		join
	end

	// -----------------------------------------------------------------
	// Hydrophones hear a channel only while it is enabled and driven.
	// -----------------------------------------------------------------
	assign monitor_o = amp_enable_i & (drive_pos_i | drive_neg_i) & ~fault_i;
endmodule : bgr_amp_model

`default_nettype wire

// File: bgr_burst_gate.sv
/*
 * Burst gate and gain ramp: selects a carrier, forms narrow drive pulses
 * of the selected gain width, gates them with the timing windows and the
 * per-channel gates, drives amplifier enables and monitors each channel.
 * Assumes carriers, monitor lines and windows arrive asynchronously from
 * pins; controller and register port are on clk_sys_i.
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
// How it works
// - Exactly one of three carriers is routed, by the carrier select lines.
// - A rising carrier edge gives a positive pulse, a falling edge a negative.
// - Pulse width is 1, 2 or 3 us for gain level 1, 2, 3.
// - Only the pulse former of the asserted gain level is enabled.
// - Pulses pass only while either timing window is active.
// - Each channel drive is the gated pulses ANDed with its channel gate.
// - Positive and negative paths are gated separately, with the same sequencing.
// - All amplifier enables are high whenever either timing window is active.
// - A detected channel malfunction raises the alarm and its red lamp.
// - A red lamp stays on while a window passes without monitored signal.
`timescale 1ns/1ns
`default_nettype none
`include "bgr_regs.svh"

module bgr_burst_gate #(
	parameter int CHANNELS = `BGR_CHANNELS,
	parameter int CLK_MHZ  = `BGR_CLK_MHZ
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   ce_i,
	input  wire logic [2:0]             carrier_i,
	input  wire logic                   low_carrier_select_i,
	input  wire logic                   mid_carrier_select_i,
	input  wire logic                   high_carrier_select_i,
	input  wire logic [2:0]             gain_select_i,
	input  wire logic                   first_timing_window_i,
	input  wire logic                   second_timing_window_i,
	input  wire logic [CHANNELS-1:0]    channel_gate_i,
	input  wire logic [CHANNELS-1:0]    missing_burst_monitor_i,
	input  wire logic [`BGR_ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]            reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [31:0]            reg_rdata_o,
	output logic      [CHANNELS-1:0]    drive_pos_o,
	output logic      [CHANNELS-1:0]    drive_neg_o,
	output logic      [CHANNELS-1:0]    amp_enable_o,
	output logic      [CHANNELS-1:0]    red_lamp_o,
	output logic      [CHANNELS-1:0]    green_lamp_o,
	output logic                        alarm_o,
	output logic                        irq_o
);
	localparam int CYC_W = 8;
	localparam logic [CYC_W-1:0] W1_CYC = CYC_W'(`BGR_PULSE1_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] W2_CYC = CYC_W'(`BGR_PULSE2_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] W3_CYC = CYC_W'(`BGR_PULSE3_US * CLK_MHZ);

	if (CHANNELS < 1 || CHANNELS > 32 || CLK_MHZ < 1 ||
	    `BGR_PULSE3_US * CLK_MHZ > 255) begin : gen_bad_param
		$error("bgr_burst_gate: unsupported CHANNELS or CLK_MHZ");
	end

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam int SW = 3 + 3 + 2 + CHANNELS;
	logic [SW-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;

	always_comb begin
		sync1_next = {carrier_i, low_carrier_select_i, mid_carrier_select_i,
		              high_carrier_select_i, first_timing_window_i,
		              second_timing_window_i, missing_burst_monitor_i};
		sync2_next = sync1_reg;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (ce_i) begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	logic [2:0]          car_s;
	logic [2:0]          fsel_s;
	logic                win_s;
	logic [CHANNELS-1:0] mon_s;
	assign car_s  = sync2_reg[SW-1 -: 3];
	assign fsel_s = sync2_reg[SW-4 -: 3];
	assign win_s  = sync2_reg[CHANNELS+1] | sync2_reg[CHANNELS];
	assign mon_s  = sync2_reg[CHANNELS-1:0];

	function automatic logic onehot3(input logic [2:0] v);
		return (v == 3'b001) || (v == 3'b010) || (v == 3'b100);
	endfunction

	// ------------------------------------------------------------------
	// Carrier select and gain decode
	// ------------------------------------------------------------------
	logic             carrier_sel;
	logic             sel_ok;
	bgr_pkg::bgr_gain_t gain;
	logic [CYC_W-1:0] width_cyc;

	always_comb begin
		sel_ok      = onehot3(fsel_s) && onehot3(gain_select_i);
		carrier_sel = (fsel_s[2] & car_s[0]) | (fsel_s[1] & car_s[1]) |
		              (fsel_s[0] & car_s[2]);
		gain        = bgr_pkg::BGR_GAIN_NONE;
		width_cyc   = '0;
		if (onehot3(gain_select_i)) begin
			unique case (gain_select_i)
				3'b001: begin
					gain      = bgr_pkg::BGR_GAIN_LOW;
					width_cyc = W1_CYC;
				end
				3'b010: begin
					gain      = bgr_pkg::BGR_GAIN_MID;
					width_cyc = W2_CYC;
				end
				3'b100: begin
					gain      = bgr_pkg::BGR_GAIN_HIGH;
					width_cyc = W3_CYC;
				end
				default: begin
					gain      = bgr_pkg::BGR_GAIN_NONE;
					width_cyc = '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pulse formers, one pair per gain level
	// ------------------------------------------------------------------
	logic [2:0] pf_pos, pf_neg;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_pf
			bgr_pulse_former #(.CYC_W(CYC_W)) u_pf (
				.clk_sys_i   (clk_sys_i),
				.sys_rst_i   (sys_rst_i),
				.ce_i        (ce_i),
				.carrier_i   (carrier_sel),
				.enable_i    (sel_ok && gain_select_i[g]),
				.width_cyc_i (width_cyc),
				.pos_pulse_o (pf_pos[g]),
				.neg_pulse_o (pf_neg[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Window gating, channel gating and amplifier enables
	// ------------------------------------------------------------------
	logic [CHANNELS-1:0] pos_reg, pos_next, neg_reg, neg_next, en_reg, en_next;
	logic                gated_pos, gated_neg;

	always_comb begin
		gated_pos = win_s && sel_ok && (|pf_pos);
		gated_neg = win_s && sel_ok && (|pf_neg);
		pos_next  = {CHANNELS{gated_pos}} & channel_gate_i;
		neg_next  = {CHANNELS{gated_neg}} & channel_gate_i;
		en_next   = {CHANNELS{win_s}};
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pos_reg <= '0;
			neg_reg <= '0;
			en_reg  <= '0;
		end else if (ce_i) begin
			pos_reg <= pos_next;
			neg_reg <= neg_next;
			en_reg  <= en_next;
		end
	end

	// ------------------------------------------------------------------
	// Channel monitor: a window with no monitored signal lights red
	// ------------------------------------------------------------------
	logic [CHANNELS-1:0] seen_reg, seen_next, red_reg, red_next, green_reg, green_next;
	logic [CHANNELS-1:0] stat_reg, stat_next, mask_reg, mask_next;
	logic                win_d_reg, win_d_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic                alarm_reg, alarm_next, irq_reg, irq_next;
	logic                win_end;

	always_comb begin
		win_d_next = win_s;
		win_end    = win_d_reg && !win_s;
		seen_next  = seen_reg;
		red_next   = red_reg;
		stat_next  = stat_reg;
		mask_next  = mask_reg;
		rdata_next = '0;
		if (win_s) begin
			seen_next = seen_reg | mon_s;
		end
		if (reg_wr_i && reg_addr_i == `BGR_REG_MASK) begin
			mask_next = reg_wdata_i[CHANNELS-1:0];
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`BGR_REG_CTRL:   rdata_next = 32'(gain);
				`BGR_REG_STATUS: rdata_next = 32'(stat_reg);
				`BGR_REG_MASK:   rdata_next = 32'(mask_reg);
				`BGR_REG_RED:    rdata_next = 32'(red_reg);
				default:         rdata_next = '0;
			endcase
			if (reg_addr_i == `BGR_REG_STATUS) begin
				stat_next = '0;
			end
		end
		if (win_end) begin
			red_next  = ~seen_reg;
			stat_next = stat_next | ~seen_reg;
			seen_next = '0;
		end
		alarm_next = |red_next;
		green_next = ~red_next;
		irq_next   = |(stat_next & mask_next);
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			win_d_reg <= 1'b0;
			seen_reg  <= '0;
			red_reg   <= '0;
			green_reg <= '1;
			stat_reg  <= '0;
			mask_reg  <= '0;
			rdata_reg <= '0;
			alarm_reg <= 1'b0;
			irq_reg   <= 1'b0;
		end else if (ce_i) begin
			win_d_reg <= win_d_next;
			seen_reg  <= seen_next;
			red_reg   <= red_next;
			green_reg <= green_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
			rdata_reg <= rdata_next;
			alarm_reg <= alarm_next;
			irq_reg   <= irq_next;
		end
	end

	assign drive_pos_o  = pos_reg;
	assign drive_neg_o  = neg_reg;
	assign amp_enable_o = en_reg;
	assign red_lamp_o   = red_reg;
	assign green_lamp_o = green_reg;
	assign alarm_o      = alarm_reg;
	assign irq_o        = irq_reg;
	assign reg_rdata_o  = rdata_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_pos_needs_window;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && !win_s && !$past(win_s) |=> drive_pos_o == '0;
	endproperty
	a_pos_needs_window: assert property (p_pos_needs_window) else $error("pulse outside window");

	property p_drive_in_gate;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i |=> ((drive_pos_o | drive_neg_o) & ~$past(channel_gate_i)) == '0;
	endproperty
	a_drive_in_gate: assert property (p_drive_in_gate) else $error("drive without gate");

	property p_enable_follows;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i |=> amp_enable_o == {CHANNELS{$past(win_s)}};
	endproperty
	a_enable_follows: assert property (p_enable_follows) else $error("enable mismatch");

	property p_no_sel_no_drive;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && !sel_ok |=> (drive_pos_o | drive_neg_o) == '0;
	endproperty
	a_no_sel_no_drive: assert property (p_no_sel_no_drive) else $error("drive unselected");

	property p_one_former;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i |=> $onehot0(pf_pos | pf_neg) &&
		         ((pf_pos | pf_neg) & ~$past(gain_select_i)) == 3'b000;
	endproperty
	a_one_former: assert property (p_one_former) else $error("several formers");

	property p_pos_rise;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && sel_ok && $rose(carrier_sel) ##1 ce_i && sel_ok |-> |pf_pos;
	endproperty
	a_pos_rise: assert property (p_pos_rise) else $error("no pulse on rise");

	property p_width_low;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		gain_select_i == 3'b001 |-> width_cyc == W1_CYC;
	endproperty
	a_width_low: assert property (p_width_low) else $error("wrong width");

	property p_red_on_miss;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && win_end && !seen_reg[0] |=> red_lamp_o[0] && alarm_o;
	endproperty
	a_red_on_miss: assert property (p_red_on_miss) else $error("missed alarm");

	property p_carrier_route;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		fsel_s == 3'b100 |-> carrier_sel == car_s[0];
	endproperty
	a_carrier_route: assert property (p_carrier_route) else $error("wrong carrier");

	c_pos_drive: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) |drive_pos_o);
	c_neg_drive: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) |drive_neg_o);
	c_alarm:     cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(alarm_o));
	c_irq:       cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(irq_o));

endmodule : bgr_burst_gate
`default_nettype wire

// File: bgr_burst_gate_tb_top.sv
/*
 * Self-checking bench for the burst gate block with the amplifier model.
 * Assumes a 25 MHz clock and the register offsets of the shared header.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bgr_regs.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module bgr_burst_gate_tb_top;
	logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
	logic        low_sel = 1'b0, mid_sel = 1'b0, high_sel = 1'b0;
	logic        win1 = 1'b0, win2 = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [2:0]  gain = 3'b000;
	logic [7:0]  gate = 8'h00, fault = 8'h00;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	wire logic [2:0]  carrier;
	wire logic [7:0]  mon, drv_p, drv_n, amp_en, red, green;
	wire logic [31:0] rdata;
	wire logic        alarm, irq;
	int mismatches = 0, checks = 0, cyc = 0;

	bgr_burst_gate bgr_burst_gate_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.carrier_i(carrier), .low_carrier_select_i(low_sel), .mid_carrier_select_i(mid_sel),
		.high_carrier_select_i(high_sel), .gain_select_i(gain), .first_timing_window_i(win1),
		.second_timing_window_i(win2), .channel_gate_i(gate), .missing_burst_monitor_i(mon),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(rdata), .drive_pos_o(drv_p), .drive_neg_o(drv_n), .amp_enable_o(amp_en),
		.red_lamp_o(red), .green_lamp_o(green), .alarm_o(alarm), .irq_o(irq));
	bgr_amp_model bgr_amp_model_i (.drive_pos_i(drv_p), .drive_neg_i(drv_n),
		.amp_enable_i(amp_en), .fault_i(fault), .carrier_o(carrier), .monitor_o(mon));

	// -----------------------------------------------------------------
	// Clock, timeout and closing report.
	// -----------------------------------------------------------------
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 45000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// -----------------------------------------------------------------
	// Register port and pulse measurement.
	// -----------------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		@(negedge clk_sys_i);
		d = rdata;
	endtask : rd_reg

	function automatic logic pin(bit neg, int ch);
		return neg ? drv_n[ch] : drv_p[ch];
	endfunction : pin

	// Width is cycles high; period is cycles from one rise to the next.
	task automatic meas(input bit neg, input int ch, output int w, output int p,
			output logic [7:0] at);
		int n;
		n = 0;
		w = 0;
		while (pin(neg, ch) !== 1'b0 && n < 500) begin @(negedge clk_sys_i); n++; end
		while (pin(neg, ch) !== 1'b1 && n < 500) begin @(negedge clk_sys_i); n++; end
		at = neg ? drv_n : drv_p;
		while (pin(neg, ch) === 1'b1 && w < 500) begin @(negedge clk_sys_i); w++; end
		p = w;
		while (pin(neg, ch) !== 1'b1 && p < 500) begin @(negedge clk_sys_i); p++; end
	endtask : meas

	// -----------------------------------------------------------------
	// Scenarios.
	// -----------------------------------------------------------------
	task automatic t_reset();
		@(negedge clk_sys_i);
		`CHK("reset drive", 8'h00, drv_p | drv_n)
		`CHK("reset enable", 8'h00, amp_en)
		`CHK("reset green", 8'hFF, green)
		`CHK("reset rdata", 32'h0000_0000, rdata)
		$display("test reset done");
	endtask : t_reset

	task automatic t_gain();
		int w, p, g;
		int per[3] = '{212, 202, 190};
		logic [7:0] at;
		logic [31:0] d;
		for (g = 1; g <= 3; g++) begin
			@(posedge clk_sys_i);
			{high_sel, mid_sel, low_sel} <= 3'b001 << (g - 1);
			gain <= 3'b001 << (g - 1);
			win1 <= 1'b1;
			gate <= 8'h04;
			repeat (100) @(posedge clk_sys_i);
			rd_reg(`BGR_REG_CTRL, d);
			`CHK("gain code", 32'(g), d)
			meas(1'b0, 2, w, p, at);
			`CHK("pos width", 25 * g, w)
			`CHK("period", 1'b1, p >= per[g-1] - 1 && p <= per[g-1] + 1)
			`CHK("pos channels", 8'h04, at)
			meas(1'b1, 2, w, p, at);
			`CHK("neg width", 25 * g, w)
			`CHK("neg channels", 8'h04, at)
			@(posedge clk_sys_i);
			win1 <= 1'b0;
		end
		$display("test gain done");
	endtask : t_gain

	task automatic t_block();
		int k;
		logic [7:0] acc;
		for (k = 0; k < 3; k++) begin
			@(posedge clk_sys_i);
			{high_sel, mid_sel} <= 2'b00;
			win2 <= (k != 0);
			gain <= (k == 1) ? 3'b000 : 3'b001;
			low_sel <= (k != 2);
			gate <= 8'hFF;
			acc = 8'h00;
			repeat (100) @(negedge clk_sys_i);
			repeat (500) begin @(negedge clk_sys_i); acc |= drv_p | drv_n; end
			`CHK("blocked drive", 8'h00, acc)
			`CHK("amp enable", (k != 0) ? 8'hFF : 8'h00, amp_en)
		end
		$display("test block done");
	endtask : t_block

	task automatic t_monitor();
		logic [31:0] d;
		@(posedge clk_sys_i);
		{win1, win2, low_sel, gain, gate, fault} <= {3'b001, 3'b001, 8'h09, 8'h08};
		repeat (20) @(posedge clk_sys_i);
		wr_reg(`BGR_REG_MASK, 32'h0000_0008);
		rd_reg(`BGR_REG_MASK, d);
		`CHK("mask", 32'h0000_0008, d)
		rd_reg(4'hF, d);
		`CHK("unmapped", 32'h0000_0000, d)
		rd_reg(`BGR_REG_STATUS, d);
		@(posedge clk_sys_i);
		win1 <= 1'b1;
		// The window carries a 1 ms burst, the shortest the controller may shape.
		repeat (25000) @(posedge clk_sys_i);
		win1 <= 1'b0;
		repeat (10) @(negedge clk_sys_i);
		`CHK("red", 8'hFE, red)
		`CHK("green", 8'h01, green)
		`CHK("alarm", 1'b1, alarm)
		`CHK("irq set", 1'b1, irq)
		rd_reg(`BGR_REG_STATUS, d);
		`CHK("status", 32'h0000_00FE, d)
		repeat (3) @(negedge clk_sys_i);
		`CHK("irq clear", 1'b0, irq)
		$display("test monitor done");
	endtask : t_monitor

	// Freezes the block in the middle of a positive pulse; nothing may move.
	task automatic t_freeze();
		@(posedge clk_sys_i);
		{high_sel, mid_sel, low_sel, gain, gate, win1} <= {3'b001, 3'b001, 8'h01, 1'b1};
		repeat (20) @(negedge clk_sys_i);
		while (drv_p[0] !== 1'b1) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		repeat (300) @(negedge clk_sys_i);
		`CHK("frozen pos drive", 8'h01, drv_p)
		`CHK("frozen neg drive", 8'h00, drv_n)
		`CHK("frozen enable", 8'hFF, amp_en)
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		win1 <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		$display("test freeze done");
	endtask : t_freeze

	initial begin
		repeat (8) @(posedge clk_sys_i);
		t_reset();
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_gain();
		t_block();
		t_monitor();
		t_freeze();
		conclude();
	end
endmodule : bgr_burst_gate_tb_top

`default_nettype wire

// File: bgr_pkg.sv
/*
 * Types shared by the burst gate and gain ramp block.
 * Assumes nothing of its surroundings.
 */
package bgr_pkg;
	typedef enum logic [1:0] {
		BGR_GAIN_NONE = 2'b00,
		BGR_GAIN_LOW  = 2'b01,
		BGR_GAIN_MID  = 2'b10,
		BGR_GAIN_HIGH = 2'b11
	} bgr_gain_t;
endpackage : bgr_pkg

// File: bgr_pulse_former.sv
/*
 * One-shot pulse former: a pulse of the selected width after each rising
 * edge (positive path) and each falling edge (negative path) of the carrier.
 * Assumes a carrier already synchronised to clk_sys_i.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bgr_regs.svh"

module bgr_pulse_former #(
	parameter int CYC_W = 8
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 ce_i,
	input  wire logic                 carrier_i,
	input  wire logic                 enable_i,
	input  wire logic [CYC_W-1:0]     width_cyc_i,
	output logic                      pos_pulse_o,
	output logic                      neg_pulse_o
);
	logic             carrier_d_reg, carrier_d_next;
	logic [CYC_W-1:0] pos_cnt_reg, pos_cnt_next;
	logic [CYC_W-1:0] neg_cnt_reg, neg_cnt_next;

	if (CYC_W < 2 || CYC_W > 16) begin : gen_bad_width
		$error("bgr_pulse_former: unsupported CYC_W");
	end

	always_comb begin
		carrier_d_next = carrier_i;
		pos_cnt_next   = pos_cnt_reg;
		neg_cnt_next   = neg_cnt_reg;
		if (pos_cnt_reg != '0) begin
			pos_cnt_next = pos_cnt_reg - 1'b1;
		end
		if (neg_cnt_reg != '0) begin
			neg_cnt_next = neg_cnt_reg - 1'b1;
		end
		if (!enable_i) begin
			pos_cnt_next = '0;
			neg_cnt_next = '0;
		end else if (carrier_i && !carrier_d_reg) begin
			pos_cnt_next = width_cyc_i;
		end else if (!carrier_i && carrier_d_reg) begin
			neg_cnt_next = width_cyc_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			carrier_d_reg <= 1'b0;
			pos_cnt_reg   <= '0;
			neg_cnt_reg   <= '0;
		end else if (ce_i) begin
			carrier_d_reg <= carrier_d_next;
			pos_cnt_reg   <= pos_cnt_next;
			neg_cnt_reg   <= neg_cnt_next;
		end
	end

	assign pos_pulse_o = (pos_cnt_reg != '0);
	assign neg_pulse_o = (neg_cnt_reg != '0);

endmodule : bgr_pulse_former
`default_nettype wire

// File: bgr_regs.svh
/*
 * Constants for the burst gate and gain ramp block: timing, channel count and
 * register offsets of the plain register port.
 * Assumes a 25 MHz system clock; included by its bare name.
 */
`ifndef BGR_REGS_SVH
`define BGR_REGS_SVH

`define BGR_CLK_MHZ        25
`define BGR_CHANNELS       8
`define BGR_PULSE1_US      1
`define BGR_PULSE2_US      2
`define BGR_PULSE3_US      3
`define BGR_ADDR_W         4
`define BGR_REG_CTRL       4'h0
`define BGR_REG_STATUS     4'h1
`define BGR_REG_MASK       4'h2
`define BGR_REG_RED        4'h3
`define BGR_CTRL_ALARM_CLR 0

`endif
